// *** tohs_output_disable.sv ***
// Output-disable unit: forces motor timer pins to high impedance on faults
`timescale 1ns/1ps
module tohs_output_disable
    import tohs_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // Wishbone classic slave
    input  wire logic                wb_cyc,
    input  wire logic                wb_stb,
    input  wire logic                wb_we,
    input  wire logic [ADDR_W-1:0]   wb_adr,
    input  wire logic [3:0]          wb_sel,
    input  wire logic [DATA_W-1:0]   wb_dat_w,
    output logic      [DATA_W-1:0]   wb_dat_r,
    output logic                     wb_ack,
    // Fault pins, active low
    input  wire logic                fault_input_zero_n,
    input  wire logic                fault_input_one_n,
    input  wire logic                fault_input_two_n,
    input  wire logic                fault_input_three_n,
    input  wire logic                fault_input_eight_n,
    // Clock stop detector level and event link pulse
    input  wire logic                osc_stop,
    input  wire logic                event_link_hiz,
    // Motor timer outputs, pairs as positive/negative bits
    input  wire logic [PWM_PINS-1:0] pwm_out,
    input  wire logic [PWM_PINS-1:0] pwm_out_en,
    input  wire logic [CH0_PINS-1:0] ch0_out,
    input  wire logic [CH0_PINS-1:0] ch0_out_en,
    // Pin drivers
    output logic      [PWM_PINS-1:0] pwm_pin_o,
    output logic      [PWM_PINS-1:0] pwm_pin_oe,
    output logic      [CH0_PINS-1:0] ch0_pin_o,
    output logic      [CH0_PINS-1:0] ch0_pin_oe,
    // Interrupt, active high level
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                  osc_s1;
        logic                  osc_s2;
        logic [PRESC_W-1:0]    presc;
        logic [IC1_MODE_W-1:0] ic1_mode;
        logic [MODE_W-1:0]     ic2_mode;
        logic                  ch0_en;
        logic [CTL_W-1:0]      ctrl;
        logic [EV_W-1:0]       stat;
        logic [EV_W-1:0]       mask;
        logic                  ack;
        logic [DATA_W-1:0]     dat;
        logic                  irq;
        logic [PWM_PINS-1:0]   pwm_o;
        logic [PWM_PINS-1:0]   pwm_oe;
        logic [CH0_PINS-1:0]   ch0_o;
        logic [CH0_PINS-1:0]   ch0_oe;
    } tohs_state_type;

    tohs_state_type q, d;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0]  old,
        input logic [DATA_W-1:0] wd,
        input logic [3:0]        sel
    );
        logic [REG_W-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Tick when the free prescaler hits the last count of a divider
    function automatic logic div_tick(
        input logic [PRESC_W-1:0] cnt,
        input int                 div
    );
        logic [PRESC_W-1:0] m;
        m = PRESC_W'(div - 1);
        return (cnt & m) == m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Fault detectors

    logic [NUM_FAULT-1:0]        fault_n;
    logic [NUM_FAULT-1:0]        fault_det;
    logic [NUM_FAULT*MODE_W-1:0] modes;
    logic [NUM_TICKS-1:0]        ticks;

    // Pin vector: inputs zero to three, then eight
    assign fault_n = {fault_input_eight_n, fault_input_three_n,
                      fault_input_two_n, fault_input_one_n,
                      fault_input_zero_n};
    assign modes   = {q.ic2_mode, q.ic1_mode};

    // Sampling ticks at the three divided rates
    assign ticks = {div_tick(q.presc, DIV_C),
                    div_tick(q.presc, DIV_B),
                    div_tick(q.presc, DIV_A)};      // R1

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULT; gi++) begin : g_det
            tohs_fault_det u_det (
                .clk    (clk),
                .nrst   (nrst),
                .pin_n  (fault_n[gi]),
                .mode   (modes[gi*MODE_W +: MODE_W]),
                .ticks  (ticks),
                .detect (fault_det[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Complementary output level comparison

    logic [NUM_PAIRS-1:0] pair_short;

    // Both outputs of a pair driven active high at this edge
    generate
        for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_cmp
            assign pair_short[gi] = pwm_out[2*gi] & pwm_out[2*gi+1] &
                                    pwm_out_en[2*gi] &
                                    pwm_out_en[2*gi+1];      // R4
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic              req;
    logic [EV_W-1:0]   ev_set;
    logic [EV_W-1:0]   ev_clr;
    logic [REG_W-1:0]  rv;
    logic [REG_W-1:0]  wv;
    logic              hiz_pwm;
    logic              hiz_ch0;

    always_comb begin
        d       = q;
        ev_set  = '0;
        ev_clr  = '0;
        rv      = REG_RESET;
        wv      = REG_RESET;
        hiz_pwm = 1'b0;
        hiz_ch0 = 1'b0;
        req     = wb_cyc & wb_stb & ~q.ack;

        // Clock stop synchroniser and free prescaler
        d.osc_s1 = osc_stop;
        d.osc_s2 = q.osc_s1;
        d.presc  = q.presc + PRESC_W'(1);

        // Events that set sticky flags
        ev_set[EV_FAULT +: NUM_GROUP] = fault_det[NUM_GROUP-1:0];
        ev_set[EV_F8]  = fault_det[FAULT_8];
        ev_set[EV_CMP] = q.ctrl[CTL_CMP_BIT] & (|pair_short);   // R4
        ev_set[EV_OST] = q.osc_s2;
        ev_set[EV_EVT] = event_link_hiz;                         // R7

        // Bus access: answer one cycle after the request
        d.ack = req;
        if (req) begin
            unique case (wb_adr)
                OFS_INPUT_CONTROL_1: begin
                    rv = {q.stat[EV_FAULT +: NUM_GROUP],
                          4'h0, q.ic1_mode};                     // R10
                    if (wb_we) begin
                        wv = merge16(rv, wb_dat_w, wb_sel);
                        d.ic1_mode = wv[IC1_MODE_W-1:0];
                        ev_clr[EV_FAULT +: NUM_GROUP] =
                            wv[IC1_FLAG_LSB +: NUM_GROUP]
                            & (wb_sel[1] ? 4'hf : 4'h0);         // R12
                    end
                end
                OFS_INPUT_CONTROL_2: begin
                    rv = REG_RESET;
                    rv[IC2_MODE_LSB +: MODE_W] = q.ic2_mode;
                    rv[IC2_CH0_BIT]  = q.ch0_en;
                    rv[IC2_FLAG_BIT] = q.stat[EV_F8];
                    if (wb_we) begin
                        wv = merge16(rv, wb_dat_w, wb_sel);
                        d.ic2_mode = wv[IC2_MODE_LSB +: MODE_W];
                        d.ch0_en   = wv[IC2_CH0_BIT];            // R9
                        ev_clr[EV_F8] = wv[IC2_FLAG_BIT] & wb_sel[1];
                    end
                end
                OFS_CONTROL: begin
                    rv = {12'h000, q.ctrl};
                    if (wb_we) begin
                        wv = merge16(rv, wb_dat_w, wb_sel);
                        d.ctrl = wv[CTL_W-1:0];                  // R6
                    end
                end
                OFS_STATUS: begin
                    rv = {8'h00, q.stat};
                    if (wb_we && wb_sel[0]) begin
                        ev_clr = wb_dat_w[EV_W-1:0];             // R12
                    end
                end
                OFS_MASK: begin
                    rv = {8'h00, q.mask};
                    if (wb_we) begin
                        wv = merge16(rv, wb_dat_w, wb_sel);
                        d.mask = wv[EV_W-1:0];
                    end
                end
                default: rv = REG_RESET;
            endcase
            d.dat = {16'h0000, rv};
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        d.stat = (q.stat & ~ev_clr) | ev_set;                    // R12

        // Complementary PWM pins float on any of their sources
        hiz_pwm = (|d.stat[EV_FAULT +: NUM_GROUP])               // R2
                | d.stat[EV_CMP]                                 // R4
                | (d.stat[EV_OST] & d.ctrl[CTL_OST_BIT])         // R5 R11
                | d.ctrl[CTL_SWP_BIT]                            // R6
                | d.stat[EV_EVT];                                // R7

        // Channel zero pins float on their sources
        hiz_ch0 = (d.stat[EV_F8] & d.ch0_en)                     // R3 R9
                | (d.stat[EV_OST] & d.ctrl[CTL_OST_BIT])         // R5 R11
                | d.ctrl[CTL_SWC_BIT]                            // R6
                | d.stat[EV_EVT];                                // R7

        // Pin drivers follow the timer unless forced off
        d.pwm_o  = pwm_out;
        d.pwm_oe = pwm_out_en & {PWM_PINS{~hiz_pwm}};
        d.ch0_o  = ch0_out;
        d.ch0_oe = ch0_out_en & {CH0_PINS{~hiz_ch0}};

        // Level interrupt from unmasked flags
        d.irq = |(d.stat & d.mask);                              // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack     = q.ack;
    assign wb_dat_r   = q.dat;
    assign pwm_pin_o  = q.pwm_o;
    assign pwm_pin_oe = q.pwm_oe;
    assign ch0_pin_o  = q.ch0_o;
    assign ch0_pin_oe = q.ch0_oe;
    assign irq        = q.irq;

endmodule // tohs_output_disable

// *** tohs_pkg.sv ***
// Constants and types shared by the output-disable unit
//
// Operation
// R1: Each fault input selects falling edge, or 16 low samples at PCLK/8/16/128.
// R2: Detection on fault inputs zero to three floats the complementary PWM pins.
// R3: Detection on fault input eight floats the timer channel zero pins.
// R4: Both outputs of a PWM pair active for a cycle floats PWM pins.
// R5: Oscillation stop floats both PWM pins and channel zero pins.
// R6: Software writes force PWM pins and channel zero pins to high impedance.
// R7: An event link signal floats PWM pins and channel zero pins.
// R8: Fault detection and PWM level comparison results can raise an interrupt.
// R9: Channel zero enable bit gates fault input eight; 0 keeps pins driven.
// R10: Fault input two has its own mode field and flag in control one.
// R11: Clock stop enable bit gates the oscillation stop response; 0 keeps driven.
// R12: High impedance holds until software clears the flag after the fault ends.
package tohs_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_INPUT_CONTROL_1 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INPUT_CONTROL_2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL         = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS          = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MASK            = 8'h10;

    // Reset value of every register
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    // Fault inputs: zero to three, then eight
    localparam int NUM_FAULT  = 5;
    localparam int NUM_GROUP  = 4;
    localparam int FAULT_8    = 4;
    localparam int MODE_W     = 2;

    // input_control_1 layout: four mode fields, flags from bit 12
    localparam int IC1_MODE_W   = NUM_GROUP * MODE_W;
    localparam int IC1_FLAG_LSB = 12;
    // input_control_2 layout: mode of input eight, channel zero enable
    localparam int IC2_MODE_LSB = 0;
    localparam int IC2_CH0_BIT  = 8;
    localparam int IC2_FLAG_BIT = 12;

    // Control register bits
    localparam int CTL_W        = 4;
    localparam int CTL_OST_BIT  = 0;
    localparam int CTL_SWP_BIT  = 1;
    localparam int CTL_SWC_BIT  = 2;
    localparam int CTL_CMP_BIT  = 3;

    // Status and mask bits
    localparam int EV_W       = 8;
    localparam int EV_FAULT   = 0;
    localparam int EV_F8      = 4;
    localparam int EV_CMP     = 5;
    localparam int EV_OST     = 6;
    localparam int EV_EVT     = 7;

    // Timer pin groups
    localparam int NUM_PAIRS = 3;
    localparam int PWM_PINS  = 2 * NUM_PAIRS;
    localparam int CH0_PINS  = 4;

    // Sampling clock division and sample count
    localparam int PRESC_W      = 7;
    localparam int DIV_A        = 8;
    localparam int DIV_B        = 16;
    localparam int DIV_C        = 128;
    localparam int NUM_TICKS    = 3;
    localparam int SAMPLE_COUNT = 16;
    localparam int SAMPLE_W     = 4;

    // Detection mode of one fault input
    typedef enum logic [MODE_W-1:0] {
        MODE_EDGE   = 2'b00,
        MODE_DIV_A  = 2'b01,
        MODE_DIV_B  = 2'b10,
        MODE_DIV_C  = 2'b11
    } tohs_mode_type;

endpackage

// *** tohs_fault_det.sv ***
// Fault input synchroniser with edge and sampled low-level detection
`timescale 1ns/1ps
module tohs_fault_det
    import tohs_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Fault pin, active low, asynchronous
    input  wire logic                 pin_n,
    // Mode and sampling ticks
    input  wire logic [MODE_W-1:0]    mode,
    input  wire logic [NUM_TICKS-1:0] ticks,
    // Detection pulse
    output logic                      detect
);

    typedef struct packed {
        logic                s1;
        logic                s2;
        logic                prev;
        logic [SAMPLE_W-1:0] cnt;
        logic                det;
    } tohs_det_state_type;

    localparam logic [SAMPLE_W-1:0] LAST = SAMPLE_W'(SAMPLE_COUNT - 1);

    tohs_det_state_type q, d;
    logic               tick;

    // Next state: edge or sampled level detection
    always_comb begin
        d      = q;
        tick   = 1'b0;
        d.s1   = pin_n;
        d.s2   = q.s1;
        d.prev = q.s2;
        d.det  = 1'b0;
        unique case (tohs_mode_type'(mode))
            MODE_EDGE: begin
                d.cnt = '0;
                d.det = q.prev & ~q.s2;                 // R1
            end
            MODE_DIV_A: tick = ticks[0];
            MODE_DIV_B: tick = ticks[1];
            MODE_DIV_C: tick = ticks[2];
        endcase
        // A high level restarts the run at once, so no count is carried
        // across a high between two samples; edge mode also clears the count
        if (q.s2) begin
            d.cnt = '0;
        end else if (tick) begin
            if (q.cnt == LAST) begin
                d.det = 1'b1;                           // R1
            end else begin
                d.cnt = q.cnt + SAMPLE_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign detect = q.det;

endmodule // tohs_fault_det

// *** tohs_monitor.sv ***
// Checker of bus and pin behaviour of the output-disable unit
`timescale 1ns/1ps
module tohs_monitor
    import tohs_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                nrst,
    // Register bus
    input wire logic                wb_cyc,
    input wire logic                wb_stb,
    input wire logic                wb_we,
    input wire logic [ADDR_W-1:0]   wb_adr,
    input wire logic [3:0]          wb_sel,
    input wire logic [DATA_W-1:0]   wb_dat_w,
    input wire logic                wb_ack,
    // Causes of high impedance
    input wire logic                fault_input_zero_n,
    input wire logic                osc_stop,
    input wire logic                event_link_hiz,
    input wire logic [PWM_PINS-1:0] pwm_out,
    input wire logic [PWM_PINS-1:0] pwm_out_en,
    input wire logic [CH0_PINS-1:0] ch0_out_en,
    // Pin enables
    input wire logic [PWM_PINS-1:0] pwm_pin_oe,
    input wire logic [CH0_PINS-1:0] ch0_pin_oe
);
    logic [CTL_W-1:0] ctl_q;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the control register, written at the taking edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= '0;
        end else if (wb_cyc && wb_stb && wb_we && !wb_ack && wb_sel[0]
                     && wb_adr == OFS_CONTROL) begin
            ctl_q <= wb_dat_w[CTL_W-1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ack_pulse;
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_ack_answer;
        wb_cyc && wb_stb && !wb_ack |=> wb_ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered in one cycle");
    property p_pwm_gate;
        (pwm_pin_oe & ~$past(pwm_out_en)) == '0;
    endproperty
    a_pwm_gate: assert property (p_pwm_gate)
        else $error("pwm pin driven while timer output disabled");
    property p_ch0_gate;
        (ch0_pin_oe & ~$past(ch0_out_en)) == '0;
    endproperty
    a_ch0_gate: assert property (p_ch0_gate)
        else $error("channel zero pin driven while output disabled");
    property p_fault_hiz;
        $fell(fault_input_zero_n) |-> ##[2:6] pwm_pin_oe == '0;
    endproperty
    a_fault_hiz: assert property (p_fault_hiz)
        else $error("fault edge did not float pwm pins");
    property p_short_hiz;
        ctl_q[CTL_CMP_BIT] && pwm_out[0] && pwm_out[1]
            && pwm_out_en[1:0] == 2'h3 |-> ##[1:2] pwm_pin_oe == '0;
    endproperty
    a_short_hiz: assert property (p_short_hiz)
        else $error("pair short did not float pwm pins");
    property p_osc_hiz;
        ctl_q[CTL_OST_BIT] && osc_stop
            |-> ##[1:4] (pwm_pin_oe == '0 && ch0_pin_oe == '0);
    endproperty
    a_osc_hiz: assert property (p_osc_hiz)
        else $error("clock stop did not float timer pins");
    property p_event_hiz;
        event_link_hiz |-> ##[1:2] (pwm_pin_oe == '0 && ch0_pin_oe == '0);
    endproperty
    a_event_hiz: assert property (p_event_hiz)
        else $error("event did not float timer pins");
    property p_sw_hiz;
        ctl_q[CTL_SWP_BIT] |-> pwm_pin_oe == '0;
    endproperty
    a_sw_hiz: assert property (p_sw_hiz)
        else $error("software force did not float pwm pins");
endmodule // tohs_monitor

bind tohs_output_disable tohs_monitor tohs_monitor_inst (
    .clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_ack, .fault_input_zero_n, .osc_stop, .event_link_hiz, .pwm_out,
    .pwm_out_en, .ch0_out_en, .pwm_pin_oe, .ch0_pin_oe
);

// *** tohs_pins_model.sv ***
// Behavioural motor timer outputs and fault pins
`timescale 1ns/1ps
module tohs_pins_model
    import tohs_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Scenario commands
    input  wire logic                 short_req,
    input  wire logic [NUM_FAULT-1:0] fault_req,
    // Timer outputs
    output logic      [PWM_PINS-1:0]  pwm_out,
    output logic      [PWM_PINS-1:0]  pwm_out_en,
    output logic      [CH0_PINS-1:0]  ch0_out,
    output logic      [CH0_PINS-1:0]  ch0_out_en,
    // Fault pins, active low
    output logic      [NUM_FAULT-1:0] fault_n
);
    logic [1:0] phase_q;
    // Free running phase of the waveform
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    // Complementary phases with dead gaps; a short drives pair zero both
    always_comb begin
        for (int i = 0; i < NUM_PAIRS; i++) begin
            pwm_out[2*i]   = phase_q == 2'h1 || (short_req && i == 0);
            pwm_out[2*i+1] = phase_q == 2'h3 || (short_req && i == 0);
        end
    end
    assign pwm_out_en = '1;
    assign ch0_out    = {2{phase_q}};
    assign ch0_out_en = '1;
    // Fault pins idle high and fall on request
    assign fault_n    = ~fault_req;
endmodule // tohs_pins_model

// *** test_timer_output_hiz_shutdown.sv ***
// Self-checking bench of the output-disable unit
`timescale 1ns/1ps
module test_timer_output_hiz_shutdown;
    import tohs_pkg::*;
    logic clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, osc_stop, irq;
    logic event_link_hiz, short_req;
    logic [ADDR_W-1:0]    wb_adr;
    logic [3:0]           wb_sel;
    logic [DATA_W-1:0]    wb_dat_w, wb_dat_r, q;
    logic [NUM_FAULT-1:0] fault_req, fault_n;
    logic [PWM_PINS-1:0]  pwm_out, pwm_out_en, pwm_pin_o, pwm_pin_oe;
    logic [CH0_PINS-1:0]  ch0_out, ch0_out_en, ch0_pin_o, ch0_pin_oe;
    int fail_count = 0;
    int comparisons = 0;
    int divs [3] = '{DIV_A, DIV_B, DIV_C};
    logic [15:0] sw_ctl [4] = '{16'h2, 16'h4, 16'h6, 16'h0};
    logic [9:0]  sw_exp [4] = '{10'h00f, 10'h3f0, 10'h000, 10'h3ff};
    localparam logic [9:0] ON = 10'h3ff;
    ////////////////////////////////////////////////////////////////////////
    // Design and far side
    tohs_output_disable tohs_output_disable_inst (
        .clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .wb_dat_r, .wb_ack, .fault_input_zero_n(fault_n[0]),
        .fault_input_one_n(fault_n[1]), .fault_input_two_n(fault_n[2]),
        .fault_input_three_n(fault_n[3]), .fault_input_eight_n(fault_n[4]),
        .osc_stop, .event_link_hiz, .pwm_out, .pwm_out_en, .ch0_out,
        .ch0_out_en, .pwm_pin_o, .pwm_pin_oe, .ch0_pin_o, .ch0_pin_oe, .irq);
    tohs_pins_model tohs_pins_model_inst (.clk, .nrst, .short_req,
        .fault_req, .pwm_out, .pwm_out_en, .ch0_out, .ch0_out_en, .fault_n);
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic finish_test;
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic check_pins(input logic [9:0] e);
        logic [9:0] prev;
        tick(2);
        prev = {pwm_out, ch0_out};
        tick(1);
        check_reg({22'h0, pwm_pin_oe, ch0_pin_oe}, {22'h0, e});
        // Pin levels are the timer outputs of the previous edge
        check_reg({22'h0, pwm_pin_o, ch0_pin_o}, {22'h0, prev});
    endtask
    task automatic check_irq(input logic e);
        tick(2);
        check_reg({31'h0, irq}, {31'h0, e});
    endtask
    // One classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h3;
        wb_dat_w <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            fail_count++;
            finish_test();
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0);
        check_reg(q, e);
    endtask
    task automatic pulse_fault(input int i);
        @(posedge clk);
        fault_req[i] <= 1'b1;
        tick(3);
        fault_req[i] <= 1'b0;
        tick(4);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 0; nrst = 0; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = '0;
        wb_sel = '0; wb_dat_w = '0; osc_stop = 0; event_link_hiz = 0;
        short_req = 0; fault_req = '0;
        tick(10);
        nrst <= 1'b1;
        // Reset values, unmapped place ignores writes
        wr(8'h14, 16'hffff);
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        check_pins(ON);
        // Event link pulse floats both groups until cleared
        @(posedge clk) event_link_hiz <= 1'b1;
        @(posedge clk) event_link_hiz <= 1'b0;
        check_pins(10'h000);
        tick(20);
        check_pins(10'h000);
        rd(OFS_STATUS, 32'h80);
        wr(OFS_STATUS, 16'h80);
        check_pins(ON);
        // Software force of each group
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CONTROL, sw_ctl[i]);
            check_pins(sw_exp[i]);
        end
        // Falling edges on inputs zero to three
        wr(OFS_MASK, 16'h1f);
        for (int i = 0; i < NUM_GROUP; i++) begin
            pulse_fault(i);
            check_pins(10'h00f);
            check_irq(1'b1);
            rd(OFS_INPUT_CONTROL_1, 32'h1000 << i);
            rd(OFS_STATUS, 32'h1 << i);
            wr(OFS_INPUT_CONTROL_1, 16'h1000 << i);
            rd(OFS_STATUS, 32'h0);
            check_pins(ON);
            check_irq(1'b0);
        end
        // Input eight only acts with the channel zero enable set
        pulse_fault(FAULT_8);
        check_pins(ON);
        wr(OFS_STATUS, 16'h10);
        wr(OFS_INPUT_CONTROL_2, 16'h100);
        pulse_fault(FAULT_8);
        check_pins(10'h3f0);
        rd(OFS_INPUT_CONTROL_2, 32'h1100);
        wr(OFS_INPUT_CONTROL_2, 16'h1100);
        check_pins(ON);
        // Sampled low level needs sixteen samples at each division
        for (int m = 1; m < 4; m++) begin
            wr(OFS_INPUT_CONTROL_1, 16'(m) << 2);
            @(posedge clk) fault_req[1] <= 1'b1;
            tick(divs[m-1] * 14);
            check_pins(ON);
            tick(divs[m-1] * 4 + 10);
            check_pins(10'h00f);
            fault_req[1] <= 1'b0;
            tick(5);
            wr(OFS_INPUT_CONTROL_1, (16'(m) << 2) | 16'h2000);
            check_pins(ON);
        end
        // Both outputs of a pair active, first with comparison off
        wr(OFS_MASK, 16'h20);
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CONTROL, 16'(c * 8));
            @(posedge clk) short_req <= 1'b1;
            tick(2);
            short_req <= 1'b0;
            check_pins(c ? 10'h00f : ON);
            check_irq(c[0]);
        end
        wr(OFS_MASK, 16'h0);
        check_irq(1'b0);
        wr(OFS_STATUS, 16'h20);
        check_pins(ON);
        // Oscillation stop, gated by its enable
        wr(OFS_CONTROL, 16'h0);
        @(posedge clk) osc_stop <= 1'b1;
        tick(5);
        check_pins(ON);
        rd(OFS_STATUS, 32'h40);
        wr(OFS_CONTROL, 16'h1);
        check_pins(10'h000);
        osc_stop <= 1'b0;
        tick(5);
        wr(OFS_STATUS, 16'h40);
        check_pins(ON);
        finish_test();
    end
endmodule // test_timer_output_hiz_shutdown
